// File: logic/adc_ctrl_defines.vh
// Register map, field positions and reset values of the converter control block
// What this block does
// R01 - Temperature channel enabled: valid temperature result sets status bit 2.
// R02 - Reading temperature or current result clears the temperature ready flag.
// R03 - Voltage channel enabled: valid voltage result sets status bit 1.
// R04 - Reading voltage or current result clears the voltage ready flag.
// R05 - Current channel enabled: valid current result sets status bit 0.
// R06 - Of the result reads, only a read of the current result clears the current ready flag.
// R07 - Calibration completion also sets ready flag of every enabled channel.
// R08 - Mask bits match low eight status bits; source enabled while bit is 1.
// R09 - Interrupt mask resets to all zeros, every source disabled.
// R10 - Mode register: eight-bit read/write, own address, resets to zero.
// R11 - Software writes zero to mode bit 7, reserved.
// R12 - Mode bit 6 set routes return through 20 kilo-ohm resistor, else ground.
// R13 - In low power modes, mode bit 5 set selects precision reference.
// R14 - Mode bits 4 to 3 select power mode; 00 is normal mode.
// R15 - Power code 01: low power, current gain 128, 131 kHz oscillator clock.
// R16 - Power code 10: low power plus, gain 512; code 11 undefined.
// R17 - Any write to the mode register clears calibration-complete status bit 15.
// R18 - Reserved bits of mode, mask and status read zero, ignore writes.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

`define ADDR_STATUS       32'hFFFF0500
`define ADDR_MASK         32'hFFFF0504
`define ADDR_MODE         32'hFFFF0508
`define ADDR_CUR_RESULT   32'hFFFF050C
`define ADDR_VOLT_RESULT  32'hFFFF0510
`define ADDR_TEMP_RESULT  32'hFFFF0514
`define ADDR_IRQ_CLEAR    32'hFFFF0518

`define MASK_RESET        8'h00
`define MODE_RESET        8'h00
`define MODE_WMASK        8'h7F
`define STATUS_MASK       16'h8007

`define ST_CUR_RDY        0
`define ST_VOLT_RDY       1
`define ST_TEMP_RDY       2
`define ST_CAL_DONE       15

`define MODE_RES_SEL      6
`define MODE_REF_SEL      5
`define MODE_PWR_HI       4
`define MODE_PWR_LO       3

`define PWR_NORMAL        2'h0
`define PWR_LOW           2'h1
`define PWR_LOW_PLUS      2'h2

`define GAIN_LOW          10'h080
`define GAIN_LOW_PLUS     10'h200

`endif

// File: logic/adc_ctrl.v
// Converter status, interrupt mask and mode registers behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_ctrl (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Converter core side
    input  wire [2:0]  chan_enable,
    input  wire        cur_valid,
    input  wire        volt_valid,
    input  wire        temp_valid,
    input  wire [15:0] cur_data,
    input  wire [15:0] volt_data,
    input  wire [15:0] temp_data,
    input  wire        cal_done,
    // Mode outputs
    output reg         res_path_sel,
    output reg         precise_ref_sel,
    output reg  [1:0]  power_mode,
    output reg         gain_forced,
    output reg  [9:0]  forced_gain,
    output reg         lp_osc_clock,
    // Interrupt
    output wire        irq
);

    // Bus state
    reg        wr_pend_q;
    reg [31:0] addr_q;
    reg [7:0]  mask_q;
    reg [7:0]  mode_q;
    reg [7:0]  mode_d;
    reg [7:0]  mask_d;
    reg        irq_q;
    reg        res_path_d;
    reg        precise_ref_d;
    reg [1:0]  power_mode_d;
    reg        gain_forced_d;
    reg [9:0]  forced_gain_d;
    reg        lp_osc_d;

    wire       access;
    wire       rd_en;
    wire       wr_en;
    wire       rd_cur;
    wire       rd_volt;
    wire       rd_temp;
    wire [2:0] ready_set;
    wire [2:0] ready_clr;
    wire [2:0] ready_d;
    wire [2:0] ready_q;
    wire       cal_d;
    wire       cal_q;
    wire       wr_mask;
    wire       wr_mode;
    wire       wr_clear;
    wire [15:0] status_d;
    wire [15:0] status_q;
    wire [15:0] cur_res_q;
    wire [15:0] volt_res_q;
    wire [15:0] temp_res_q;

    assign access    = hsel & hready & htrans[1];
    assign rd_en     = access & ~hwrite;
    assign wr_en     = wr_pend_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign rd_cur  = rd_en & (haddr == `ADDR_CUR_RESULT);
    assign rd_volt = rd_en & (haddr == `ADDR_VOLT_RESULT);
    assign rd_temp = rd_en & (haddr == `ADDR_TEMP_RESULT);

    // Ready events from conversions and calibration end
    assign ready_set[`ST_CUR_RDY]  = chan_enable[0] & (cur_valid | cal_done);  // R05 R07
    assign ready_set[`ST_VOLT_RDY] = chan_enable[1] & (volt_valid | cal_done); // R03 R07
    assign ready_set[`ST_TEMP_RDY] = chan_enable[2] & (temp_valid | cal_done); // R01 R07

    // Write phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 32'h00000000;
        end else begin
            wr_pend_q <= access & hwrite;
            addr_q    <= haddr;
        end
    end

    // Result capture, independent of channel enables
    result_reg #(
        .WIDTH   (16)
    ) u_cur_res (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (cur_valid),
        .data_in (cur_data),
        .data_q  (cur_res_q)
    );

    result_reg #(
        .WIDTH   (16)
    ) u_volt_res (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (volt_valid),
        .data_in (volt_data),
        .data_q  (volt_res_q)
    );

    result_reg #(
        .WIDTH   (16)
    ) u_temp_res (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (temp_valid),
        .data_in (temp_data),
        .data_q  (temp_res_q)
    );

    // Write decode for the data phase
    assign wr_mask  = wr_en & (addr_q == `ADDR_MASK);
    assign wr_mode  = wr_en & (addr_q == `ADDR_MODE);
    assign wr_clear = wr_en & (addr_q == `ADDR_IRQ_CLEAR);

    // Ready clears from result reads and the clear register
    assign ready_clr[`ST_CUR_RDY]  = rd_cur | (wr_clear & hwdata[`ST_CUR_RDY]); // R06
    assign ready_clr[`ST_VOLT_RDY] = rd_cur | rd_volt | (wr_clear & hwdata[`ST_VOLT_RDY]); // R04
    assign ready_clr[`ST_TEMP_RDY] = rd_cur | rd_temp | (wr_clear & hwdata[`ST_TEMP_RDY]); // R02

    // Sticky status flags; set wins over clear
    ready_flag #(
        .RESET_VALUE (1'b0)
    ) u_cur_flag (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .set_evt     (ready_set[`ST_CUR_RDY]), // R05
        .clr_evt     (ready_clr[`ST_CUR_RDY]), // R06
        .flag_d      (ready_d[`ST_CUR_RDY]),
        .flag_q      (ready_q[`ST_CUR_RDY])
    );

    ready_flag #(
        .RESET_VALUE (1'b0)
    ) u_volt_flag (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .set_evt     (ready_set[`ST_VOLT_RDY]), // R03
        .clr_evt     (ready_clr[`ST_VOLT_RDY]), // R04
        .flag_d      (ready_d[`ST_VOLT_RDY]),
        .flag_q      (ready_q[`ST_VOLT_RDY])
    );

    ready_flag #(
        .RESET_VALUE (1'b0)
    ) u_temp_flag (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .set_evt     (ready_set[`ST_TEMP_RDY]), // R01
        .clr_evt     (ready_clr[`ST_TEMP_RDY]), // R02
        .flag_d      (ready_d[`ST_TEMP_RDY]),
        .flag_q      (ready_q[`ST_TEMP_RDY])
    );

    ready_flag #(
        .RESET_VALUE (1'b0)
    ) u_cal_flag (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .set_evt     (cal_done),
        .clr_evt     (wr_mode), // R17
        .flag_d      (cal_d),
        .flag_q      (cal_q)
    );

    // Status word; reserved bits read zero
    assign status_q = {cal_q, 12'h000, ready_q} & `STATUS_MASK; // R18
    assign status_d = {cal_d, 12'h000, ready_d} & `STATUS_MASK; // R18

    // Mode next value
    always @* begin
        mode_d = mode_q;
        if (wr_en && addr_q == `ADDR_MODE) begin
            mode_d = hwdata[7:0] & `MODE_WMASK; // R10 R18
        end
    end

    // Mask next value
    always @* begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = hwdata[7:0]; // R08
        end
    end

    // Registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= `MASK_RESET; // R09
            mode_q <= `MODE_RESET; // R10
            irq_q  <= 1'b0;
        end else begin
            mask_q <= mask_d;
            mode_q <= mode_d;
            irq_q  <= |(status_d[7:0] & mask_d); // R08
        end
    end

    // Read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_en) begin
            case (haddr)
                `ADDR_STATUS:      hrdata <= {16'h0000, status_q};
                `ADDR_MASK:        hrdata <= {24'h000000, mask_q};
                `ADDR_MODE:        hrdata <= {24'h000000, mode_q};
                `ADDR_CUR_RESULT:  hrdata <= {16'h0000, cur_res_q};
                `ADDR_VOLT_RESULT: hrdata <= {16'h0000, volt_res_q};
                `ADDR_TEMP_RESULT: hrdata <= {16'h0000, temp_res_q};
                default:           hrdata <= 32'h00000000;
            endcase
        end
    end

    // Mode decode next values
    always @* begin
        res_path_d    = mode_q[`MODE_RES_SEL]; // R12
        power_mode_d  = mode_q[`MODE_PWR_HI:`MODE_PWR_LO]; // R14
        precise_ref_d = 1'b1;
        gain_forced_d = 1'b0;
        forced_gain_d = 10'h000;
        lp_osc_d      = 1'b0;
        case (mode_q[`MODE_PWR_HI:`MODE_PWR_LO])
            `PWR_LOW: begin
                precise_ref_d = mode_q[`MODE_REF_SEL]; // R13
                gain_forced_d = 1'b1; // R15
                forced_gain_d = `GAIN_LOW; // R15
                lp_osc_d      = 1'b1; // R15
            end
            `PWR_LOW_PLUS: begin
                precise_ref_d = mode_q[`MODE_REF_SEL]; // R13
                gain_forced_d = 1'b1; // R16
                forced_gain_d = `GAIN_LOW_PLUS; // R16
            end
            default: begin
                precise_ref_d = 1'b1;
                gain_forced_d = 1'b0; // R14 R16
            end
        endcase
    end

    // Mode output registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_path_sel    <= 1'b0;
            precise_ref_sel <= 1'b0;
            power_mode      <= `PWR_NORMAL;
            gain_forced     <= 1'b0;
            forced_gain     <= 10'h000;
            lp_osc_clock    <= 1'b0;
        end else begin
            res_path_sel    <= res_path_d;
            precise_ref_sel <= precise_ref_d;
            power_mode      <= power_mode_d;
            gain_forced     <= gain_forced_d;
            forced_gain     <= forced_gain_d;
            lp_osc_clock    <= lp_osc_d;
        end
    end

    // Interrupt
    assign irq = irq_q; // R08

endmodule // adc_ctrl

// Sticky status flag with set priority
module ready_flag #(
    parameter RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire hclk,
    input  wire hresetn,
    // Flag events
    input  wire set_evt,
    input  wire clr_evt,
    // Flag state
    output reg  flag_d,
    output reg  flag_q
);

    // Next value; a set in the clear cycle wins
    always @* begin
        flag_d = flag_q;
        if (clr_evt) begin
            flag_d = 1'b0;
        end
        if (set_evt) begin
            flag_d = 1'b1;
        end
    end

    // Flag register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= RESET_VALUE;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule // ready_flag

// Result capture register, loaded on its valid pulse
module result_reg #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // Result input
    input  wire             load,
    input  wire [WIDTH-1:0] data_in,
    // Held result
    output reg  [WIDTH-1:0] data_q
);

    // Capture on every valid pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= {WIDTH{1'b0}};
        end else if (load) begin
            data_q <= data_in;
        end
    end

endmodule // result_reg

// File: testbench/adc_ctrl_chk.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_ctrl_chk (
    // Clock, reset and bus
    input logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input logic [31:0] haddr, hwdata, hrdata,
    input logic [1:0]  htrans, power_mode,
    // Converter side
    input logic        cur_valid, volt_valid, temp_valid, cal_done, irq,
    input logic        res_path_sel, precise_ref_sel, gain_forced, lp_osc_clock,
    input logic [9:0]  forced_gain
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire go = hsel && hready && htrans[1];
    a_zero_wait: assert property (hreadyout && !hresp) else $error("bus stall");
    a_normal_mode: assert property (power_mode == 2'h0 && $past(hresetn) |->
        !gain_forced && precise_ref_sel && !lp_osc_clock) else $error("normal mode");
    a_low_power: assert property (power_mode == 2'h1 |->
        gain_forced && forced_gain == 10'h080 && lp_osc_clock) else $error("low power");
    a_low_plus: assert property (power_mode == 2'h2 |->
        gain_forced && forced_gain == 10'h200 && !lp_osc_clock) else $error("low plus");
    a_mode_apply: assert property (go && hwrite && haddr == `ADDR_MODE |-> ##3
        power_mode == $past(hwdata[4:3], 2) && res_path_sel == $past(hwdata[6], 2))
        else $error("mode not applied");
    a_ref_select: assert property ((go && hwrite && haddr == `ADDR_MODE) ##1
        (hwdata[4:3] == 2'h1 || hwdata[4:3] == 2'h2) |-> ##2
        precise_ref_sel == $past(hwdata[5], 2))
        else $error("reference select");
    a_irq_cause: assert property ($rose(irq) |->
        $past(cur_valid || volt_valid || temp_valid || cal_done) || $past(go && hwrite, 2))
        else $error("irq without cause");
    a_mode_reserved: assert property (go && !hwrite && haddr == `ADDR_MODE |=>
        hrdata[31:7] == 25'h0) else $error("mode reserved bits");
    a_status_reserved: assert property (go && !hwrite && haddr == `ADDR_STATUS |=>
        hrdata[31:16] == 16'h0 && hrdata[14:3] == 12'h0) else $error("status reserved bits");
endmodule // adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout,
    .hresp, .haddr, .hwdata, .hrdata, .htrans, .power_mode, .cur_valid, .volt_valid,
    .temp_valid, .cal_done, .irq, .res_path_sel, .precise_ref_sel, .gain_forced,
    .lp_osc_clock, .forced_gain);

// File: testbench/testbench.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
    // Bus and converter stimulus
    reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    reg  [1:0]  htrans = 0;
    reg  [31:0] haddr = 0, hwdata = 0, r, v;
    reg  [2:0]  en = 0;
    reg  [3:0]  ev = 0;
    reg  [15:0] dat = 0;
    // Observed outputs
    wire        hready, rp, pr, gf, lo, irq;
    wire [31:0] hrdata;
    wire [1:0]  pm;
    wire [9:0]  fg;
    integer     failures = 0, check_count = 0, seed = 12, i;
    adc_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(), .hrdata(hrdata), .chan_enable(en), .cur_valid(ev[0]),
        .volt_valid(ev[1]), .temp_valid(ev[2]), .cur_data(dat), .volt_data(dat),
        .temp_data(dat), .cal_done(ev[3]), .res_path_sel(rp), .precise_ref_sel(pr),
        .power_mode(pm), .gain_forced(gf), .forced_gain(fg), .lp_osc_clock(lo), .irq(irq));
    initial forever #4 hclk = ~hclk;
    task xfer(input [31:0] a, input w, input [31:0] d);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task rd(input [31:0] a, input [31:0] e);
        xfer(a, 0, 0);
        `CHK(r, e)
    endtask
    task st(input [2:0] f, input c);
        rd(`ADDR_STATUS, {16'h0, c, 12'h0, f});
    endtask
    task pulse(input [3:0] m);
        @(posedge hclk);
        ev <= m; dat <= $random(seed);
        @(posedge hclk);
        ev <= 0;
        #1;
    endtask
    function [15:0] exp_mode(input [7:0] m);
        case (m[4:3])
            2'h1: exp_mode = {m[6], m[5], 2'h1, 1'b1, 10'h080, 1'b1};
            2'h2: exp_mode = {m[6], m[5], 2'h2, 1'b1, 10'h200, 1'b0};
            default: exp_mode = {m[6], 1'b1, m[4:3], 1'b0, 10'h000, 1'b0};
        endcase
    endfunction
    task give_verdict;
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        give_verdict;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        rd(`ADDR_MASK, 32'h0);
        rd(`ADDR_MODE, 32'h0);
        st(3'h0, 0);
        en <= 3'h7;
        pulse(4'h2); pulse(4'h4); pulse(4'h1);
        st(3'h7, 0);
        rd(`ADDR_CUR_RESULT, {16'h0, dat});
        st(3'h0, 0);
        pulse(4'h7);
        xfer(`ADDR_VOLT_RESULT, 0, 0);
        st(3'h5, 0);
        xfer(`ADDR_TEMP_RESULT, 0, 0);
        st(3'h1, 0);
        xfer(`ADDR_CUR_RESULT, 0, 0);
        en <= 3'h1;
        pulse(4'h6);
        st(3'h0, 0);
        en <= 3'h6;
        pulse(4'h8);
        st(3'h6, 1);
        xfer(`ADDR_MODE, 1, 0);
        st(3'h6, 0);
        xfer(`ADDR_CUR_RESULT, 0, 0);
        en <= 3'h7;
        v = $random(seed) | 32'h1;
        xfer(`ADDR_MASK, 1, v);
        rd(`ADDR_MASK, v & 32'hFF);
        pulse(4'h1);
        `CHK(irq, 1'b1)
        xfer(`ADDR_MASK, 1, v & 32'hF8);
        #1 `CHK(irq, 1'b0)
        xfer(`ADDR_MASK, 1, 32'h1);
        #1 `CHK(irq, 1'b1)
        xfer(`ADDR_IRQ_CLEAR, 1, 32'h1);
        #1 `CHK(irq, 1'b0)
        st(3'h0, 0);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            v[4:3] = i[1:0];
            v[7] = 1'b0;
            xfer(`ADDR_MODE, 1, v);
            rd(`ADDR_MODE, v & 32'h7F);
            `CHK({rp, pr, pm, gf, fg, lo}, exp_mode(v[7:0]))
        end
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        rd(`ADDR_MASK, 32'h0);
        rd(`ADDR_MODE, 32'h0);
        `CHK(irq, 1'b0)
        rd(`ADDR_IRQ_CLEAR, 32'h0);
        rd(32'hFFFF051C, 32'h0);
        give_verdict;
    end
endmodule // testbench
